// *** rtl/abs_pos_mon_pkg.sv ***
/*
  Package for the absolute position error monitor: error codes, timing and carriers.
  Assumes a 125 MHz system clock.
*/
package abs_pos_mon_pkg;
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned CHECK_PERIOD_US = 3500;
  localparam int unsigned CHECK_CYCLES = (CLK_HZ / 1000000) * CHECK_PERIOD_US;
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_HOME_REQ = 16'h2eea;
  localparam logic [15:0] ERR_ENC_COMM = 16'h2ef4;
  localparam logic [15:0] ERR_ENC_JUMP = 16'h2efe;
  localparam logic [15:0] ERR_ENC_MISMATCH = 16'h2f08;
  localparam logic [15:0] ERR_MISMATCH_CONT = 16'h2f12;
  localparam logic [15:0] SERVO_ERR_A = 16'h07e9;
  localparam logic [15:0] SERVO_ERR_B = 16'h085f;
  localparam logic [15:0] SERVO_ERR_C = 16'h0b61;
  localparam logic [15:0] MAJOR_ERR_A = 16'h04b2;
  localparam logic [15:0] MAJOR_ERR_B = 16'h04b3;
  localparam logic [15:0] MAJOR_ERR_C = 16'h04b4;
  localparam logic [31:0] POS_RESET = 32'h0000_0000;

  typedef struct packed {
    logic        amp_power_on;
    logic        enc_comm_fail;
    logic        servo_err_valid;
    logic [15:0] servo_err_code;
    logic        major_err_valid;
    logic [15:0] major_err_code;
    logic        abs_data_lost;
    logic        dir_param_changed;
    logic        mismatch_cont;
  } amp_status_t;

  typedef struct packed {
    logic home_start;
    logic home_done;
    logic home_fail;
  } home_ctl_t;

  typedef enum logic [1:0] {
    HOME_NEVER = 2'b00,
    HOME_RUN   = 2'b01,
    HOME_OK    = 2'b10,
    HOME_REQ   = 2'b11
  } home_state_t;
endpackage

// *** rtl/abs_pos_mon.sv ***
/*
  Per-axis absolute position error monitor.
  Assumes the amplifier-side status and position words arrive synchronous to sys_clk.
*/
module abs_pos_mon
  import abs_pos_mon_pkg::*;
#(
  parameter int unsigned POS_W = 32,
  parameter int unsigned ENC_BITS = 18,
  parameter int unsigned CHECK_CNT = CHECK_CYCLES,
  parameter bit COMM_FAIL_REQ = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire amp_status_t amp_st,
  input wire home_ctl_t home_ctl,
  input wire logic [POS_W-1:0] enc_pos,
  input wire logic [POS_W-1:0] fb_pos,
  output logic home_req,
  output logic err_valid,
  output logic [15:0] err_code,
  output logic warn_continue
);
  // ==========================================================
  // Interval and home state
  localparam logic [31:0] HALF_REV = 32'(1) << (ENC_BITS - 1);
  localparam logic [31:0] ENC_MASK = (32'(1) << ENC_BITS) - 32'(1);

  home_state_t home_ff, nxt_home;
  logic [31:0] tick_ff, nxt_tick;
  logic [31:0] ref_ff, nxt_ref;
  logic req_ff, nxt_req;
  logic errv_ff, nxt_errv;
  logic [15:0] code_ff, nxt_code;
  logic warn_ff, nxt_warn;

  logic servo_hit, major_hit, jump_hit, mism_hit, comm_hit, any_req;
  logic [31:0] enc_cur, delta;

  // ==========================================================
  // Encoder checks and fault decode
  always_comb begin
    // Jump is measured on the full multi-turn count, so a wrap of the single-turn bits is no jump.
    enc_cur = enc_pos[31:0];
    delta = enc_cur - ref_ff;
    if (delta[31]) begin
      delta = ref_ff - enc_cur;
    end
    servo_hit = amp_st.servo_err_valid && (amp_st.servo_err_code == SERVO_ERR_A ||
      amp_st.servo_err_code == SERVO_ERR_B || amp_st.servo_err_code == SERVO_ERR_C);
    major_hit = amp_st.major_err_valid && (amp_st.major_err_code == MAJOR_ERR_A ||
      amp_st.major_err_code == MAJOR_ERR_B || amp_st.major_err_code == MAJOR_ERR_C ||
      amp_st.major_err_code == ERR_ENC_COMM || amp_st.major_err_code == ERR_ENC_JUMP ||
      amp_st.major_err_code == ERR_ENC_MISMATCH);
    comm_hit = amp_st.amp_power_on && amp_st.enc_comm_fail;
    jump_hit = amp_st.amp_power_on && (tick_ff == 32'(CHECK_CNT - 1)) &&
      (delta > HALF_REV);
    mism_hit = amp_st.amp_power_on &&
      ((enc_pos[31:0] & ENC_MASK) != (fb_pos[31:0] & ENC_MASK));
    any_req = servo_hit || major_hit || jump_hit || mism_hit || amp_st.abs_data_lost ||
      amp_st.dir_param_changed || home_ctl.home_fail || (comm_hit && COMM_FAIL_REQ);
  end

  // ==========================================================
  // Next state
  always_comb begin
    nxt_home = home_ff;
    nxt_tick = tick_ff;
    nxt_ref = ref_ff;
    nxt_req = req_ff;
    nxt_errv = errv_ff;
    nxt_code = code_ff;
    nxt_warn = amp_st.amp_power_on && amp_st.mismatch_cont;
    if (!amp_st.amp_power_on) begin
      nxt_tick = 32'h0000_0000;
      nxt_ref = enc_cur;
    end else if (tick_ff == 32'(CHECK_CNT - 1)) begin
      nxt_tick = 32'h0000_0000;
      nxt_ref = enc_cur;
    end else begin
      nxt_tick = tick_ff + 32'(1);
    end
    case (home_ff)
      HOME_NEVER: begin
        nxt_req = 1'b1;
        if (home_ctl.home_start) begin
          nxt_home = HOME_RUN;
        end
      end
      HOME_RUN: begin
        if (home_ctl.home_fail) begin
          nxt_home = HOME_REQ;
        end else if (home_ctl.home_done) begin
          nxt_home = HOME_OK;
          nxt_req = 1'b0;
          nxt_errv = 1'b0;
          nxt_code = ERR_NONE;
        end
      end
      HOME_OK: begin
        if (home_ctl.home_start) begin
          nxt_home = HOME_RUN;
        end
      end
      HOME_REQ: begin
        nxt_req = 1'b1;
        if (home_ctl.home_start) begin
          nxt_home = HOME_RUN;
        end
      end
      default: begin
        nxt_home = HOME_NEVER;
      end
    endcase
    if (home_ff == HOME_NEVER || home_ff == HOME_REQ) begin
      nxt_errv = 1'b1;
      nxt_code = ERR_HOME_REQ;
    end
    if (any_req) begin
      if (home_ff != HOME_RUN || home_ctl.home_fail) begin
        nxt_home = HOME_REQ;
      end
      nxt_req = 1'b1;
      nxt_errv = 1'b1;
      if (jump_hit) begin
        nxt_code = ERR_ENC_JUMP;
      end else if (mism_hit) begin
        nxt_code = ERR_ENC_MISMATCH;
      end else if (comm_hit) begin
        nxt_code = ERR_ENC_COMM;
      end else begin
        nxt_code = ERR_HOME_REQ;
      end
    end else if (comm_hit) begin
      nxt_errv = 1'b1;
      nxt_code = ERR_ENC_COMM;
    end else if (nxt_warn && !errv_ff) begin
      nxt_errv = 1'b1;
      nxt_code = ERR_MISMATCH_CONT;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      home_ff <= HOME_NEVER;
      tick_ff <= 32'h0000_0000;
      ref_ff <= POS_RESET;
      req_ff <= 1'b1;
      errv_ff <= 1'b0;
      code_ff <= ERR_NONE;
      warn_ff <= 1'b0;
    end else begin
      home_ff <= nxt_home;
      tick_ff <= nxt_tick;
      ref_ff <= nxt_ref;
      req_ff <= nxt_req;
      errv_ff <= nxt_errv;
      code_ff <= nxt_code;
      warn_ff <= nxt_warn;
    end
  end

  assign home_req = req_ff;
  assign err_valid = errv_ff;
  assign err_code = code_ff;
  assign warn_continue = warn_ff;

  // ==========================================================
  // Assertions
  a_never_homed_req: assert property (@(posedge sys_clk) disable iff (!rst_b)
    home_ff == HOME_NEVER |-> home_req) else $error("home request low before first return");
  a_fail_sets_req: assert property (@(posedge sys_clk) disable iff (!rst_b)
    home_ff == HOME_RUN && home_ctl.home_fail |=> home_req && err_code == ERR_HOME_REQ)
    else $error("failed return did not request home");
  a_lost_sets_req: assert property (@(posedge sys_clk) disable iff (!rst_b)
    amp_st.abs_data_lost |=> home_req) else $error("lost data no request");
  a_servo_err_req: assert property (@(posedge sys_clk) disable iff (!rst_b)
    servo_hit |=> home_req && err_valid) else $error("servo fault no request");
  a_major_err_req: assert property (@(posedge sys_clk) disable iff (!rst_b)
    major_hit |=> home_req) else $error("major error no request");
  a_dir_change_req: assert property (@(posedge sys_clk) disable iff (!rst_b)
    amp_st.dir_param_changed |=> home_req) else $error("direction change no request");
  a_comm_err_code: assert property (@(posedge sys_clk) disable iff (!rst_b)
    comm_hit && !jump_hit && !mism_hit |=> err_code == ERR_ENC_COMM && err_valid)
    else $error("comm fault code wrong");
  a_jump_err_code: assert property (@(posedge sys_clk) disable iff (!rst_b)
    jump_hit |=> err_code == ERR_ENC_JUMP && home_req) else $error("jump not flagged");
  a_tick_runs_on: assert property (@(posedge sys_clk) disable iff (!rst_b)
    amp_st.amp_power_on && tick_ff < 32'(CHECK_CNT - 1) |=> tick_ff == $past(tick_ff) + 32'(1))
    else $error("interval counter stalled");
  a_mismatch_code: assert property (@(posedge sys_clk) disable iff (!rst_b)
    mism_hit && !jump_hit |=> err_code == ERR_ENC_MISMATCH && home_req)
    else $error("mismatch not flagged");
  a_warn_no_req: assert property (@(posedge sys_clk) disable iff (!rst_b)
    home_ff == HOME_OK && !any_req && !home_ctl.home_start && amp_st.mismatch_cont
    && amp_st.amp_power_on |=> !home_req && warn_continue)
    else $error("continue warning raised request");
  a_req_holds: assert property (@(posedge sys_clk) disable iff (!rst_b)
    home_req && !(home_ff == HOME_RUN && home_ctl.home_done) |=> home_req)
    else $error("request dropped early");
  c_home_done: cover property (@(posedge sys_clk) disable iff (!rst_b)
    home_ff == HOME_RUN ##1 home_ff == HOME_OK);
  c_jump_seen: cover property (@(posedge sys_clk) disable iff (!rst_b) jump_hit);
  c_warn_seen: cover property (@(posedge sys_clk) disable iff (!rst_b)
    warn_continue && !home_req);
  c_comm_seen: cover property (@(posedge sys_clk) disable iff (!rst_b)
    comm_hit ##1 err_code == ERR_ENC_COMM);
  c_mismatch_seen: cover property (@(posedge sys_clk) disable iff (!rst_b)
    mism_hit ##1 err_code == ERR_ENC_MISMATCH);
endmodule

// *** tb/amp_model.sv ***
/*
  Servo amplifier model with its encoder: drives the status and position words.
  Assumes the bench calls its tasks just after a rising edge of sys_clk.
*/
module amp_model
  import abs_pos_mon_pkg::*;
(
  output amp_status_t amp_st,
  output logic [31:0] enc_pos,
  output logic [31:0] fb_pos
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Amplifier powered, no faults, positions at rest.
  initial begin
    amp_st = '0;
    amp_st.amp_power_on = 1'b1;
    enc_pos = POS_RESET;
    fb_pos = POS_RESET;
  end
  task automatic set_pos(input logic [31:0] e, input logic [31:0] f);
    enc_pos = e;
    fb_pos = f;
  endtask
  task automatic set_st(input amp_status_t s);
    amp_st = s;
  endtask
endmodule

// *** tb/abs_pos_mon_tb.sv ***
/*
  Self-checking bench for the absolute position error monitor.
  Assumes the amplifier model drives status and positions synchronous to sys_clk.
*/
module abs_pos_mon_tb
  import abs_pos_mon_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CNT = 20;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  home_ctl_t home_ctl = '0;
  amp_status_t amp_st;
  amp_status_t st;
  logic [31:0] enc_pos;
  logic [31:0] fb_pos;
  logic [31:0] r;
  logic home_req;
  logic err_valid;
  logic warn_continue;
  logic [15:0] err_code;
  int bad_count = 0;
  int comparisons = 0;
  int seed = 40780;
  int exp_req = 1;
  int exp_code = 0;
  int exp_warn = 0;
  int k;
  int codes[9] = '{2025, 2143, 2913, 1202, 1203, 1204, 12020, 12030, 12040};
  // ==========================================================
  // Clock, partner and design.
  always #4 sys_clk = ~sys_clk;
  amp_model amp_model_inst (.amp_st(amp_st), .enc_pos(enc_pos), .fb_pos(fb_pos));
  abs_pos_mon #(.CHECK_CNT(CNT)) abs_pos_mon_inst (.sys_clk(sys_clk), .rst_b(rst_b),
    .amp_st(amp_st), .home_ctl(home_ctl), .enc_pos(enc_pos), .fb_pos(fb_pos),
    .home_req(home_req), .err_valid(err_valid), .err_code(err_code),
    .warn_continue(warn_continue));
  // ==========================================================
  // Tasks.
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk_out();
    comparisons++;
    if (home_req !== exp_req[0] || err_code !== 16'(exp_code) ||
        warn_continue !== exp_warn[0] || err_valid !== (exp_code != 0)) begin
      bad_count++;
      $display("[FAIL] outputs expected req=%0d code=%0d warn=%0d seen req=%b code=%0d warn=%b",
        exp_req, exp_code, exp_warn, home_req, err_code, warn_continue);
    end
  endtask
  task automatic home(input logic ok);
    home_ctl.home_start = 1'b1;
    step(1);
    home_ctl = '0;
    home_ctl.home_done = ok;
    home_ctl.home_fail = !ok;
    step(1);
    home_ctl = '0;
    step(2);
    exp_req = !ok;
    exp_code = ok ? 0 : 12010;
    exp_warn = 0;
  endtask
  task automatic conclude();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ==========================================================
  // Watchdog.
  initial begin
    #(20000 * 8);
    bad_count++;
    conclude();
  end
  // ==========================================================
  // Scenarios.
  initial begin
    step(8);
    chk_out();
    rst_b = 1'b1;
    step(2);
    exp_code = 12010;
    chk_out();
    home(1'b1);
    chk_out();
    home(1'b0);
    chk_out();
    home(1'b1);
    for (k = 0; k < 11; k++) begin
      st = '0;
      st.amp_power_on = 1'b1;
      st.servo_err_valid = k < 3;
      st.major_err_valid = k > 2 && k < 9;
      st.servo_err_code = (k < 3) ? 16'(codes[k]) : 16'h0000;
      st.major_err_code = (k > 2 && k < 9) ? 16'(codes[k]) : 16'h0000;
      st.abs_data_lost = k == 9;
      st.dir_param_changed = k == 10;
      amp_model_inst.set_st(st);
      step(1);
      st = '0;
      st.amp_power_on = 1'b1;
      amp_model_inst.set_st(st);
      step(2);
      exp_req = 1;
      exp_code = 12010;
      chk_out();
      step(5);
      chk_out();
      home(1'b1);
      chk_out();
    end
    r = $random(seed);
    amp_model_inst.set_pos({16'h0000, r[15:0]}, {r[31:18], 2'b00, r[15:0]});
    step(2 * CNT + 4);
    chk_out();
    amp_model_inst.set_pos({16'h0000, r[15:0]}, {16'h0000, r[15:1], !r[0]});
    step(2);
    exp_req = 1;
    exp_code = 12040;
    chk_out();
    amp_model_inst.set_pos({16'h0000, r[15:0]}, {16'h0000, r[15:0]});
    step(2);
    home(1'b1);
    amp_model_inst.set_pos({16'h0000, r[15:0]} + 32'h0002_0000,
      {16'h0000, r[15:0]} + 32'h0002_0000);
    step(2 * CNT + 4);
    chk_out();
    amp_model_inst.set_pos({16'h0000, r[15:0]} + 32'h0004_0001,
      {16'h0000, r[15:0]} + 32'h0004_0001);
    for (k = 0; k < 2 * CNT + 4 && err_code !== ERR_ENC_JUMP; k++)
      step(1);
    exp_req = 1;
    exp_code = 12030;
    chk_out();
    home(1'b1);
    st = '0;
    st.amp_power_on = 1'b1;
    st.mismatch_cont = 1'b1;
    amp_model_inst.set_st(st);
    step(2);
    exp_code = 12050;
    exp_warn = 1;
    chk_out();
    st = '0;
    amp_model_inst.set_st(st);
    step(2);
    st.amp_power_on = 1'b1;
    st.enc_comm_fail = 1'b1;
    amp_model_inst.set_st(st);
    step(2);
    exp_req = 1;
    exp_code = 12020;
    exp_warn = 0;
    chk_out();
    conclude();
  end
endmodule
